// >>> verilog/rxd_map.svh
// Register offsets, field positions, widths and reset values of the receive decoder
`ifndef RXD_MAP_SVH
`define RXD_MAP_SVH
`define RXD_LANES 4
`define RXD_SYM_W 10
`define RXD_BYTE_W 8
`define RXD_IN_W 40
`define RXD_ADR_W 8
`define RXD_DAT_W 32
`define RXD_SEL_W 4
`define RXD_EVT_W 4
`define RXD_OFS_CTRL 8'h00
`define RXD_OFS_STATUS 8'h04
`define RXD_OFS_MASK 8'h08
`define RXD_CTRL_DEC_EN 0
`define RXD_CTRL_INT_WIDE 1
`define RXD_CTRL_WSEL_LO 2
`define RXD_CTRL_NEG_EN 4
`define RXD_CTRL_POS_EN 5
`define RXD_CTRL_RESTR 6
`define RXD_STS_DERR 0
`define RXD_STS_NIT 1
`define RXD_STS_COMMA 2
`define RXD_STS_WSEL_RSV 3
`define RXD_STS_RD 8
`define RXD_RST_DEC_EN 1'h1
`define RXD_RST_INT_WIDE 1'h1
`define RXD_RST_WSEL 2'h0
`define RXD_RST_NEG_EN 1'h1
`define RXD_RST_POS_EN 1'h1
`define RXD_RST_RESTR 1'h0
`define RXD_RST_RD 1'h0
`define RXD_MASK_1BYTE 4'h1
`define RXD_MASK_2BYTE 4'h3
`define RXD_MASK_4BYTE 4'hF
`endif

// >>> verilog/rxd_pkg.sv
// Types shared by the receive decoder modules
`default_nettype none
`include "rxd_map.svh"
package rxd_pkg;
  typedef enum logic [1:0] {
    RXD_W1   = 2'h0,
    RXD_W2   = 2'h1,
    RXD_W4   = 2'h2,
    RXD_WRSV = 2'h3
  } rxd_wsel_e;

  typedef struct packed {
    logic                   dec_en;
    logic                   int_wide;
    rxd_wsel_e              wsel;
    logic                   neg_en;
    logic                   pos_en;
    logic                   restr;
    logic [`RXD_EVT_W-1:0]  sts;
    logic [`RXD_EVT_W-1:0]  msk;
    logic                   ack;
    logic [`RXD_DAT_W-1:0]  rdat;
    logic [`RXD_IN_W-1:0]   s1_sym;
    logic                   s1_vld;
    logic [`RXD_LANES-1:0]  s1_act;
    logic                   rd;
    logic [`RXD_IN_W-1:0]   word;
    logic                   word_vld;
    logic [`RXD_LANES-1:0]  k;
    logic [`RXD_LANES-1:0]  comma;
    logic [`RXD_LANES-1:0]  derr;
    logic [`RXD_LANES-1:0]  nit;
    logic [`RXD_LANES-1:0]  rdo;
    logic                   irq;
  } rxd_state_s;

  localparam rxd_state_s RXD_STATE_RST = '{
    dec_en:   `RXD_RST_DEC_EN,
    int_wide: `RXD_RST_INT_WIDE,
    wsel:     rxd_wsel_e'(`RXD_RST_WSEL),
    neg_en:   `RXD_RST_NEG_EN,
    pos_en:   `RXD_RST_POS_EN,
    restr:    `RXD_RST_RESTR,
    rd:       `RXD_RST_RD,
    default:  '0
  };
endpackage : rxd_pkg
`default_nettype wire

// >>> verilog/rxd_sym_dec.sv
// Combinational decode of one received 10-bit symbol
`timescale 1ns/1ps
`default_nettype none
`include "rxd_map.svh"
module rxd_sym_dec (
  input  wire logic [`RXD_SYM_W-1:0]  sym,
  input  wire logic                   rd_in,
  input  wire logic                   neg_en,
  input  wire logic                   pos_en,
  input  wire logic                   restr,
  output logic      [`RXD_BYTE_W-1:0] data,
  output logic                        is_k,
  output logic                        is_comma,
  output logic                        disp_err,
  output logic                        not_in_table,
  output logic                        rd_out
);
  // Six-bit codes for the negative running disparity, indexed by the five data bits
  localparam logic [5:0] ENC6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};

  logic [`RXD_SYM_W-1:0] rev;
  logic [5:0]            c6;
  logic [3:0]            raw4;
  logic [3:0]            f4;
  logic [4:0]            x;
  logic [2:0]            y;
  logic                  v6;
  logic                  v4;
  logic                  k28;
  logic                  alt_k;
  logic                  pos6;
  logic                  neg6;
  logic                  pos4;
  logic                  neg4;
  logic                  rd_mid;
  logic                  neg_hit;
  logic                  pos_hit;

  always_comb begin
    for (int i = 0; i < `RXD_SYM_W; i++) begin
      rev[`RXD_SYM_W-1-i] = sym[i];
    end
    c6   = rev[9:4];
    raw4 = rev[3:0];
    k28  = (c6 == 6'h0F) || (c6 == 6'h30);
    v6   = k28;
    x    = k28 ? 5'h1C : 5'h00;
    for (int i = 0; i < 32; i++) begin
      // Balanced codes other than D7 have one form only; their complement is another code
      if (!v6 && (c6 == ENC6[i] || (c6 == ~ENC6[i] && ($countones(ENC6[i]) != 3 || i == 7)))) begin
        v6 = 1'b1;
        x  = 5'(i);
      end
    end
    // Positive-disparity K28 carries the inverted four-bit block
    f4 = (c6 == 6'h30) ? ~raw4 : raw4;
    v4 = 1'b1;
    case (f4)
      4'hB, 4'h4:             y = 3'h0;
      4'h9:                   y = 3'h1;
      4'h5:                   y = 3'h2;
      4'hC, 4'h3:             y = 3'h3;
      4'hD, 4'h2:             y = 3'h4;
      4'hA:                   y = 3'h5;
      4'h6:                   y = 3'h6;
      4'hE, 4'h1, 4'h7, 4'h8: y = 3'h7;
      default: begin
        y  = 3'h0;
        v4 = 1'b0;
      end
    endcase
    alt_k = v6 && !k28 && (x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E)
            && (c6[0] ? raw4 == 4'h7 : raw4 == 4'h8);
    is_k         = v6 && v4 && (k28 || alt_k);
    data         = {y, x};
    not_in_table = !(v6 && v4);
    pos6   = ($countones(c6) == 4) || (c6 == 6'h07);
    neg6   = ($countones(c6) == 2) || (c6 == 6'h38);
    rd_mid = pos6 ? 1'b1 : (neg6 ? 1'b0 : rd_in);
    pos4   = ($countones(raw4) == 3) || (raw4 == 4'h3);
    neg4   = ($countones(raw4) == 1) || (raw4 == 4'hC);
    rd_out = pos4 ? 1'b1 : (neg4 ? 1'b0 : rd_mid);
    disp_err = (pos6 && rd_in) || (neg6 && !rd_in) || (pos4 && rd_mid) || (neg4 && !rd_mid);
    neg_hit = 1'b0;
    pos_hit = 1'b0;
    if (restr) begin
      neg_hit = k28 && v4 && (c6 == 6'h0F) && (y == 3'h1 || y == 3'h5 || y == 3'h7);
      pos_hit = k28 && v4 && (c6 == 6'h30) && (y == 3'h1 || y == 3'h5 || y == 3'h7);
    end else begin
      for (int j = 0; j < 4; j++) begin
        neg_hit = neg_hit || (rev[9-j -: 7] == 7'h1F);
        pos_hit = pos_hit || (rev[9-j -: 7] == 7'h60);
      end
    end
    is_comma = (neg_hit && neg_en) || (pos_hit && pos_en);
  end
endmodule : rxd_sym_dec
`default_nettype wire

// >>> verilog/rxd_top.sv
// Receive 8B/10B decoder with Wishbone control, status and interrupt
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rxd_map.svh"
// Notes on behaviour
// - Decode only while decode enable is set; otherwise bypass with less latency.
// - Bypassed bytes carry as many bits as the internal width gives.
// - Word width select: 0 one byte, 1 two, 2 four; 3 is reserved.
// - Status bit n of each flag vector describes byte lane n.
// - Control character flag marks decoded K characters; low while bypassed.
// - Comma flag marks enabled commas; low while bypassed.
// - Negative commas raise the comma flag only when their detect bit is set.
// - Positive commas raise the comma flag only when their detect bit is set.
// - Restricted set limits comma flag to K28.1, K28.5 and K28.7.
// - Comma flag ignores the aligner's programmable comma patterns.
// - Running disparity tracked; each lane reports the disparity it arrived under.
// - Disparity error flag marks symbols arriving with wrong disparity.
// - Invalid code flag marks symbols that are not valid 8B/10B codes.
// - Each symbol is bit-reversed before lookup so a0 is first.
// - Two-byte word: first byte in bits 7:0, second in 15:8.
// - Four-byte word: fourth byte in bits 31:24, earlier bytes lower.
// - Internal width select: 0 means 8-bit, 1 means 10-bit bytes per lane; decoded bytes are always 8-bit.
module rxd_top (
  input  wire logic                    MCLK,
  input  wire logic                    SYS_RST,
  input  wire logic [`RXD_IN_W-1:0]    RX_SYM_IN,
  input  wire logic                    RX_SYM_VALID,
  output logic      [`RXD_IN_W-1:0]    RX_WORD,
  output logic                         RX_WORD_VALID,
  output logic      [`RXD_LANES-1:0]   CONTROL_CHAR_FLAG,
  output logic      [`RXD_LANES-1:0]   COMMA_FLAG,
  output logic      [`RXD_LANES-1:0]   DISPARITY_ERROR_FLAG,
  output logic      [`RXD_LANES-1:0]   INVALID_CODE_FLAG,
  output logic      [`RXD_LANES-1:0]   RUNNING_DISPARITY_OUT,
  output logic                         IRQ,
  input  wire logic                    WB_CYC_I,
  input  wire logic                    WB_STB_I,
  input  wire logic                    WB_WE_I,
  input  wire logic [`RXD_ADR_W-1:0]   WB_ADR_I,
  input  wire logic [`RXD_SEL_W-1:0]   WB_SEL_I,
  input  wire logic [`RXD_DAT_W-1:0]   WB_DAT_I,
  output logic      [`RXD_DAT_W-1:0]   WB_DAT_O,
  output logic                         WB_ACK_O
);
  import rxd_pkg::*;

  rxd_state_s              st_ff;
  rxd_state_s              nxt_st;

  logic [`RXD_BYTE_W-1:0]  dec_data [`RXD_LANES];
  logic [`RXD_LANES-1:0]   dec_k;
  logic [`RXD_LANES-1:0]   dec_comma;
  logic [`RXD_LANES-1:0]   dec_derr;
  logic [`RXD_LANES-1:0]   dec_nit;
  logic [`RXD_LANES-1:0]   dec_rd;
  logic [`RXD_LANES:0]     lane_rd;

  logic                    req;
  logic                    wr;
  logic [`RXD_EVT_W-1:0]   clr;
  logic [`RXD_EVT_W-1:0]   set;
  logic [`RXD_DAT_W-1:0]   rdat;
  logic [`RXD_LANES-1:0]   in_act;

  // Lane 0 holds the first received symbol, so disparity ripples upward
  assign lane_rd[0] = st_ff.rd;

  genvar g;
  generate
    for (g = 0; g < `RXD_LANES; g++) begin : g_lane
      rxd_sym_dec u_dec (
        .sym          (st_ff.s1_sym[`RXD_SYM_W*g +: `RXD_SYM_W]),
        .rd_in        (lane_rd[g]),
        .neg_en       (st_ff.neg_en),
        .pos_en       (st_ff.pos_en),
        .restr        (st_ff.restr),
        .data         (dec_data[g]),
        .is_k         (dec_k[g]),
        .is_comma     (dec_comma[g]),
        .disp_err     (dec_derr[g]),
        .not_in_table (dec_nit[g]),
        .rd_out       (dec_rd[g])
      );
      // Idle lanes pass the disparity through untouched
      assign lane_rd[g+1] = st_ff.s1_act[g] ? dec_rd[g] : lane_rd[g];
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;

    // Lanes in use for the word width currently selected
    case (st_ff.wsel)
      RXD_W1: begin
        in_act = `RXD_MASK_1BYTE;
      end
      RXD_W2: begin
        in_act = `RXD_MASK_2BYTE;
      end
      default: begin
        // Reserved code behaves as four bytes and is reported in status
        in_act = `RXD_MASK_4BYTE;
      end
    endcase

    // Wishbone slave: one wait state, unmapped reads return zero
    req = WB_CYC_I & WB_STB_I & ~st_ff.ack;
    wr  = req & WB_WE_I & WB_SEL_I[0];
    nxt_st.ack = req;
    clr = '0;
    if (wr && WB_ADR_I == `RXD_OFS_CTRL) begin
      nxt_st.dec_en   = WB_DAT_I[`RXD_CTRL_DEC_EN];
      nxt_st.int_wide = WB_DAT_I[`RXD_CTRL_INT_WIDE];
      nxt_st.wsel     = rxd_wsel_e'(WB_DAT_I[`RXD_CTRL_WSEL_LO +: 2]);
      nxt_st.neg_en   = WB_DAT_I[`RXD_CTRL_NEG_EN];
      nxt_st.pos_en   = WB_DAT_I[`RXD_CTRL_POS_EN];
      nxt_st.restr    = WB_DAT_I[`RXD_CTRL_RESTR];
    end
    if (wr && WB_ADR_I == `RXD_OFS_MASK) begin
      nxt_st.msk = WB_DAT_I[`RXD_EVT_W-1:0];
    end
    if (wr && WB_ADR_I == `RXD_OFS_STATUS) begin
      clr = WB_DAT_I[`RXD_EVT_W-1:0];
    end

    rdat = '0;
    case (WB_ADR_I)
      `RXD_OFS_CTRL: begin
        rdat[`RXD_CTRL_DEC_EN]          = st_ff.dec_en;
        rdat[`RXD_CTRL_INT_WIDE]        = st_ff.int_wide;
        rdat[`RXD_CTRL_WSEL_LO +: 2]    = st_ff.wsel;
        rdat[`RXD_CTRL_NEG_EN]          = st_ff.neg_en;
        rdat[`RXD_CTRL_POS_EN]          = st_ff.pos_en;
        rdat[`RXD_CTRL_RESTR]           = st_ff.restr;
      end
      `RXD_OFS_STATUS: begin
        rdat[`RXD_EVT_W-1:0]            = st_ff.sts;
        rdat[`RXD_STS_RD]               = st_ff.rd;
      end
      `RXD_OFS_MASK: begin
        rdat[`RXD_EVT_W-1:0]            = st_ff.msk;
      end
      default: begin
        rdat = '0;
      end
    endcase
    if (req) begin
      nxt_st.rdat = rdat;
    end

    set = '0;
    if (RX_SYM_VALID && st_ff.wsel == RXD_WRSV) begin
      set[`RXD_STS_WSEL_RSV] = 1'b1;
    end

    // Decode path spends one cycle in the input stage before lookup
    nxt_st.s1_vld = RX_SYM_VALID & st_ff.dec_en;
    if (RX_SYM_VALID) begin
      nxt_st.s1_sym = RX_SYM_IN;
      nxt_st.s1_act = in_act;
    end

    if (st_ff.dec_en) begin
      nxt_st.word_vld = st_ff.s1_vld;
      if (st_ff.s1_vld) begin
        nxt_st.word  = '0;
        nxt_st.k     = '0;
        nxt_st.comma = '0;
        nxt_st.derr  = '0;
        nxt_st.nit   = '0;
        nxt_st.rdo   = '0;
        for (int i = 0; i < `RXD_LANES; i++) begin
          if (st_ff.s1_act[i]) begin
            nxt_st.word[`RXD_BYTE_W*i +: `RXD_BYTE_W] = dec_data[i];
            nxt_st.k[i]     = dec_k[i];
            nxt_st.comma[i] = dec_comma[i];
            nxt_st.derr[i]  = dec_derr[i];
            nxt_st.nit[i]   = dec_nit[i];
            nxt_st.rdo[i]   = lane_rd[i];
          end
        end
        nxt_st.rd = lane_rd[`RXD_LANES];
        set[`RXD_STS_DERR]  = |nxt_st.derr;
        set[`RXD_STS_NIT]   = |nxt_st.nit;
        set[`RXD_STS_COMMA] = |nxt_st.comma;
      end
    end else begin
      // Bypass skips the input stage, so the word appears one cycle sooner
      nxt_st.word_vld = RX_SYM_VALID;
      if (RX_SYM_VALID) begin
        nxt_st.word  = '0;
        nxt_st.k     = '0;
        nxt_st.comma = '0;
        nxt_st.derr  = '0;
        nxt_st.nit   = '0;
        nxt_st.rdo   = '0;
        for (int i = 0; i < `RXD_LANES; i++) begin
          if (in_act[i]) begin
            if (st_ff.int_wide) begin
              nxt_st.word[`RXD_SYM_W*i +: `RXD_SYM_W] = RX_SYM_IN[`RXD_SYM_W*i +: `RXD_SYM_W];
            end else begin
              nxt_st.word[`RXD_BYTE_W*i +: `RXD_BYTE_W] = RX_SYM_IN[`RXD_SYM_W*i +: `RXD_BYTE_W];
            end
          end
        end
      end
    end

    // A new event wins over a clear written in the same cycle
    nxt_st.sts = (st_ff.sts & ~clr) | set;
    nxt_st.irq = |(nxt_st.sts & nxt_st.msk);
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_ff <= RXD_STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign RX_WORD               = st_ff.word;
  assign RX_WORD_VALID         = st_ff.word_vld;
  assign CONTROL_CHAR_FLAG     = st_ff.k;
  assign COMMA_FLAG            = st_ff.comma;
  assign DISPARITY_ERROR_FLAG  = st_ff.derr;
  assign INVALID_CODE_FLAG     = st_ff.nit;
  assign RUNNING_DISPARITY_OUT = st_ff.rdo;
  assign IRQ                   = st_ff.irq;
  assign WB_DAT_O              = st_ff.rdat;
  assign WB_ACK_O              = st_ff.ack;
endmodule : rxd_top
`default_nettype wire

// >>> test/rxd_top_sva.sv
// Port-level assertions for the receive decoder
`timescale 1ns/1ps
`default_nettype none
`include "rxd_map.svh"
module rxd_chk (
  input wire logic                  MCLK,
  input wire logic                  SYS_RST,
  input wire logic [`RXD_IN_W-1:0]  RX_SYM_IN,
  input wire logic                  RX_SYM_VALID,
  input wire logic [`RXD_IN_W-1:0]  RX_WORD,
  input wire logic                  RX_WORD_VALID,
  input wire logic [`RXD_LANES-1:0] CONTROL_CHAR_FLAG,
  input wire logic [`RXD_LANES-1:0] COMMA_FLAG,
  input wire logic                  WB_CYC_I,
  input wire logic                  WB_STB_I,
  input wire logic                  WB_WE_I,
  input wire logic [`RXD_ADR_W-1:0] WB_ADR_I,
  input wire logic [`RXD_SEL_W-1:0] WB_SEL_I,
  input wire logic [`RXD_DAT_W-1:0] WB_DAT_I,
  input wire logic                  WB_ACK_O
);
  // Shadow of the control register, since the mode is not visible at the ports
  logic [6:0] ctl_ff;
  logic       wr_ctl;
  logic       byp;
  logic       dec;
  assign wr_ctl = WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == `RXD_OFS_CTRL;
  assign byp = RX_SYM_VALID && !ctl_ff[0];
  assign dec = RX_SYM_VALID && ctl_ff[0];
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctl_ff <= 7'h33;
    end else if (wr_ctl) begin
      ctl_ff <= WB_DAT_I[6:0];
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  chk_byp_lat: assert property (byp |=> RX_WORD_VALID)
    else $error("bypass word not one cycle on");
  chk_dec_lat: assert property (dec |-> ##2 RX_WORD_VALID)
    else $error("decoded word not two cycles on");
  chk_byp_flags: assert property (byp |=> CONTROL_CHAR_FLAG == 0 && COMMA_FLAG == 0)
    else $error("flags raised in bypass");
  chk_byp_raw: assert property (byp && ctl_ff[3:1] == 3'h5 |=> RX_WORD == $past(RX_SYM_IN))
    else $error("bypass word differs from symbols");
  chk_one_lane: assert property (dec && ctl_ff[3:2] == 2'h0 |-> ##2 RX_WORD[39:8] == 0 && CONTROL_CHAR_FLAG[3:1] == 0)
    else $error("unused lanes active in one-byte mode");
  chk_comma_off: assert property (dec && ctl_ff[5:4] == 2'h0 |-> ##2 COMMA_FLAG == 0)
    else $error("comma flag with detection off");
  chk_flag_hold: assert property (!RX_WORD_VALID |-> $stable(CONTROL_CHAR_FLAG) && $stable(COMMA_FLAG))
    else $error("flags moved without a word");
  chk_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus answer late");
  chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("bus answer longer than one cycle");
endmodule : rxd_chk
bind rxd_top rxd_chk i_chk (.MCLK, .SYS_RST, .RX_SYM_IN, .RX_SYM_VALID, .RX_WORD, .RX_WORD_VALID,
  .CONTROL_CHAR_FLAG, .COMMA_FLAG, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_ACK_O);
`default_nettype wire

// >>> test/rxd_sink_model.sv
// Fabric-side sink that takes each output word with its flags
`timescale 1ns/1ps
`default_nettype none
module rxd_sink (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [39:0] word,
  input  wire logic        vld,
  input  wire logic [19:0] flags,
  output logic      [39:0] word_ff,
  output logic      [19:0] flags_ff,
  output logic      [7:0]  cnt_ff
);
  // Flags are taken only with their own word, never on a later cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_ff <= '0;
      flags_ff <= '0;
      cnt_ff <= '0;
    end else if (vld) begin
      word_ff <= word;
      flags_ff <= flags;
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
endmodule : rxd_sink
`default_nettype wire

// >>> test/test_rxd_top.sv
// Testbench for the receive decoder
`timescale 1ns/1ps
`default_nettype none
module test_rxd_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [39:0] sym = '0;
  logic        sv = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = '0;
  logic [31:0] wdat = '0;
  logic [39:0] rx_word;
  logic        rx_vld;
  logic [3:0]  k, cm, de, ni, rdo;
  logic        irq;
  logic [31:0] rdat, q;
  logic        ack;
  logic [39:0] wd;
  logic [19:0] fl;
  logic [7:0]  cnt;
  int          fail_count = 0;
  int          n_compared = 0;
  localparam logic [39:0] SYMS = {10'h27C, 10'h155, 10'h283, 10'h17C};
  always #5 clk = ~clk;
  rxd_top i_dut (.MCLK(clk), .SYS_RST(rst), .RX_SYM_IN(sym), .RX_SYM_VALID(sv), .RX_WORD(rx_word),
    .RX_WORD_VALID(rx_vld), .CONTROL_CHAR_FLAG(k), .COMMA_FLAG(cm), .DISPARITY_ERROR_FLAG(de),
    .INVALID_CODE_FLAG(ni), .RUNNING_DISPARITY_OUT(rdo), .IRQ(irq), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));
  rxd_sink i_sink (.clk(clk), .rst(rst), .word(rx_word), .vld(rx_vld), .flags({rdo, ni, de, cm, k}),
    .word_ff(wd), .flags_ff(fl), .cnt_ff(cnt));
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input logic [39:0] msk);
    n_compared++;
    if ((got & msk) !== (exp & msk)) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  task automatic rst_dut();
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : rst_dut
  // The slave's answer time is not assumed; the loop bound only guards a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t bus answer missing", $time);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic send(input logic [39:0] s);
    int i;
    logic [7:0] c0;
    c0 = cnt;
    @(posedge clk);
    sym <= s;
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    i = 0;
    while (cnt === c0 && i < 10) begin
      @(posedge clk);
      i++;
    end
    if (cnt === c0) begin
      fail_count++;
      $display("[ERR] %0t no output word", $time);
    end
  endtask : send
  initial begin
    #100000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
  initial begin
    rst_dut();
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 40'h33, 40'h7F);
    wb(1'b1, 8'h00, 32'h3B);
    send(SYMS);
    chk(wd, 40'h003CB5BCBC, '1);
    chk(fl, 20'h200BB, '1);
    send({10'h155, 10'h000, 10'h283, 10'h283});
    chk(fl, 20'h14211, 20'h37311);
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 40'h7, 40'hF);
    chk(irq, 40'h0, 40'h1);
    wb(1'b1, 8'h08, 32'h2);
    @(posedge clk);
    chk(irq, 40'h1, 40'h1);
    wb(1'b1, 8'h04, 32'h7);
    @(posedge clk);
    chk(irq, 40'h0, 40'h1);
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 40'h0, 40'h7);
    wb(1'b0, 8'h0C, 32'h0);
    chk(q, 40'h0, '1);
    rst_dut();
    // Each word leaves the disparity negative again, so the loop needs no reset
    for (int n = 0; n < 4; n++) begin
      wb(1'b1, 8'h00, 32'h07 | (n << 4));
      send({20'h0, 10'h283, 10'h17C});
      chk(wd, 40'hBCBC, '1);
      chk(fl, {4'h2, 8'h0, 2'b00, n[1:0], 4'h3}, '1);
    end
    for (int r = 0; r < 2; r++) begin
      rst_dut();
      wb(1'b1, 8'h00, 32'h33 | (r << 6));
      send(40'h17C);
      chk(fl, 20'h00010, 20'h00010);
      send(40'h3FC);
      chk(fl, (r == 0) ? 20'h01010 : 20'h01000, 20'h01010);
      chk(wd, 40'h0, 40'hFFFFFFFF00);
    end
    for (int w = 0; w < 2; w++) begin
      wb(1'b1, 8'h00, 32'h08 | (w << 1));
      send(SYMS);
      chk(wd, (w == 1) ? SYMS : 40'h7C55837C, '1);
      chk(fl, 20'h0, '1);
    end
    wb(1'b1, 8'h00, 32'h3F);
    send(SYMS);
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 40'h8, 40'h8);
    results();
  end
endmodule : test_rxd_top
`default_nettype wire
